// ==== src/sfd_pkg.sv ====
package sfd_pkg;

  // operation codes, sent most significant bit first
  localparam logic [7:0] OP_RDSR     = 8'h05;
  localparam logic [7:0] OP_RDFS     = 8'h70;
  localparam logic [7:0] OP_READ     = 8'h03;
  localparam logic [7:0] OP_RDCR     = 8'hB5;
  localparam logic [7:0] OP_RDID     = 8'h9F;
  localparam logic [7:0] OP_FRD      = 8'h0B;
  localparam logic [7:0] OP_DRD      = 8'hBB;
  localparam logic [7:0] OP_QRD      = 8'hEB;
  localparam logic [7:0] OP_WREN     = 8'h06;
  localparam logic [7:0] OP_WRDI     = 8'h04;
  localparam logic [7:0] OP_WRSR     = 8'h01;
  localparam logic [7:0] OP_PP       = 8'h02;
  localparam logic [7:0] OP_WRCR     = 8'hB1;
  localparam logic [7:0] OP_DPP      = 8'hD2;
  localparam logic [7:0] OP_QPP      = 8'h12;
  localparam logic [7:0] OP_QPP2     = 8'h38;
  localparam logic [7:0] OP_BE       = 8'hC7;
  localparam logic [7:0] OP_SE       = 8'hD8;
  localparam logic [7:0] OP_SSE      = 8'h20;
  localparam logic [7:0] OP_WIDE_IN  = 8'hB7;
  localparam logic [7:0] OP_WIDE_OUT = 8'hE9;

  // cycle and bit counts
  localparam logic [3:0] ID_DUMMY    = 4'h2;
  localparam logic [3:0] FAST_DUMMY  = 4'h8;
  localparam logic [3:0] QUAD_DUMMY  = 4'hA;
  localparam logic [5:0] OPC_LAST    = 6'h07;
  localparam logic [5:0] BYTE_BITS   = 6'h08;
  localparam logic [5:0] ADDR_BITS_3 = 6'h18;
  localparam logic [5:0] ADDR_BITS_4 = 6'h20;
  localparam logic [1:0] CR_BYTES    = 2'h2;

  // configuration register layout and reset value
  localparam logic [15:0] CR_RST     = 16'hFFFF;
  localparam int          CR_DUM_MSB = 15;
  localparam int          CR_DUM_LSB = 12;
  localparam int          CR_ADDR    = 0;

  // status and flag status bit positions
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int FS_RDY = 7;
  localparam int FS_ADR = 0;

  // serial data lines, line three down to line zero
  typedef struct packed {
    logic three;
    logic two;
    logic one;
    logic zero;
  } sfd_lines_t;

  // command phase, one-hot
  typedef enum logic [5:0] {
    ST_OPC   = 6'h01,
    ST_ADDR  = 6'h02,
    ST_DUMMY = 6'h04,
    ST_DOUT  = 6'h08,
    ST_DIN   = 6'h10,
    ST_DONE  = 6'h20
  } sfd_state_t;

endpackage

// ==== src/sfd_cmd_decoder.sv ====
// Overview of operation
// - 05h streams status register until chip select rises
// - 70h streams flag status register continuously
// - 03h takes 3 or 4 address bytes, no dummy; host keeps clock slow
// - plain read samples address on rise, drives line one on fall, MSB first
// - read address advances per byte and wraps to zero at top
// - array read opcode during busy cycle is ignored
// - B5h returns both configuration register bytes
// - 9Fh inserts two dummy clocks then one identification byte
// - 0Bh and BBh take address, default 8 dummy, then stream
// - EBh takes address, default 10 dummy, then streams on four lines
// - fast read dummy count comes from configuration register
// - 06h sets write enable latch
// - 04h clears write enable latch
// - latch clears at reset and at end of every program or erase
// - 02h needs address and data; only last 256 bytes land in page
// - D2h, 12h and 38h are dual and quad page writes
// - B1h takes exactly two data bytes into configuration register
// - opcode on line zero; B7h enters, E9h leaves 4-byte addressing
// - opcodes arrive most significant bit first
// - register bits 15:12 of 1..14 give dummy count, else default
// - register bit 0 low selects 4-byte addressing at power-up
`timescale 1ns/1ns
module sfd_cmd_decoder
#(
  parameter int unsigned ARRAY_AW  = 24,
  parameter logic [15:0] CR_INIT   = sfd_pkg::CR_RST,
  parameter logic [7:0]  DEVICE_ID = 8'h5A  // arbitrary value
)
(
  // clock and reset
  input  wire logic                ref_clk_in,
  input  wire logic                arst_n_in,
  // serial pins
  input  wire logic                chip_select_low_in,
  input  wire logic                serial_clock_in,
  input  wire sfd_pkg::sfd_lines_t serial_lines_in,
  output      sfd_pkg::sfd_lines_t serial_lines_out,
  output      sfd_pkg::sfd_lines_t serial_lines_oe_out,
  // memory array port
  output      logic                array_rd_out,
  output      logic                array_wr_out,
  output      logic [31:0]         array_addr_out,
  output      logic [7:0]          array_wdata_out,
  input  wire logic [7:0]          array_rdata_in,
  // self-timed operation engine
  output      logic                op_start_out,
  output      logic [7:0]          op_code_out,
  input  wire logic                busy_in,
  input  wire logic                op_done_in,
  // status
  input  wire logic [7:0]          status_ext_in,
  input  wire logic [7:0]          flag_ext_in,
  output      logic                write_enable_out,
  output      logic                wide_address_out,
  output      logic [15:0]         config_out
);

  function automatic logic [2:0] lane_w(input logic [7:0] op);
    case (op)
      sfd_pkg::OP_DRD, sfd_pkg::OP_DPP:                   lane_w = 3'h2;
      sfd_pkg::OP_QRD, sfd_pkg::OP_QPP, sfd_pkg::OP_QPP2: lane_w = 3'h4;
      default:                                            lane_w = 3'h1;
    endcase
  endfunction

  function automatic logic [31:0] shift_in(input logic [31:0] sr,
                                           input sfd_pkg::sfd_lines_t l,
                                           input logic [2:0] w);
    case (w)
      3'h2:    shift_in = {sr[29:0], l.one, l.zero};
      3'h4:    shift_in = {sr[27:0], l};
      default: shift_in = {sr[30:0], l.zero};
    endcase
  endfunction

  function automatic logic is_array_rd(input logic [7:0] op);
    is_array_rd = (op == sfd_pkg::OP_READ) || (op == sfd_pkg::OP_FRD) ||
                  (op == sfd_pkg::OP_DRD) || (op == sfd_pkg::OP_QRD);
  endfunction

  function automatic logic is_page(input logic [7:0] op);
    is_page = (op == sfd_pkg::OP_PP) || (op == sfd_pkg::OP_DPP) ||
              (op == sfd_pkg::OP_QPP) || (op == sfd_pkg::OP_QPP2);
  endfunction

  function automatic logic is_prog(input logic [7:0] op);
    is_prog = is_page(op) || (op == sfd_pkg::OP_WRSR) || (op == sfd_pkg::OP_BE) ||
              (op == sfd_pkg::OP_SE) || (op == sfd_pkg::OP_SSE);
  endfunction

  function automatic logic [3:0] dummy_for(input logic [7:0] op, input logic [15:0] cr);
    logic [3:0] f;
    f = cr[sfd_pkg::CR_DUM_MSB:sfd_pkg::CR_DUM_LSB];
    if (op == sfd_pkg::OP_RDID)
      dummy_for = sfd_pkg::ID_DUMMY;
    else if ((op == sfd_pkg::OP_FRD) || (op == sfd_pkg::OP_DRD) || (op == sfd_pkg::OP_QRD))
      dummy_for = ((f != 4'h0) && (f != 4'hF)) ? f :
                  (op == sfd_pkg::OP_QRD) ? sfd_pkg::QUAD_DUMMY : sfd_pkg::FAST_DUMMY;
    else
      dummy_for = 4'h0;
  endfunction

  // phase after the eighth opcode bit
  function automatic sfd_pkg::sfd_state_t opc_next(input logic [7:0] op, input logic busy);
    if ((is_array_rd(op) || (op == sfd_pkg::OP_RDID)) && busy)
      opc_next = sfd_pkg::ST_DONE;
    else if (is_array_rd(op) || is_page(op) || (op == sfd_pkg::OP_SE) ||
             (op == sfd_pkg::OP_SSE))
      opc_next = sfd_pkg::ST_ADDR;
    else if ((op == sfd_pkg::OP_RDSR) || (op == sfd_pkg::OP_RDFS) || (op == sfd_pkg::OP_RDCR))
      opc_next = sfd_pkg::ST_DOUT;
    else if (op == sfd_pkg::OP_RDID)
      opc_next = sfd_pkg::ST_DUMMY;
    else if ((op == sfd_pkg::OP_WRSR) || (op == sfd_pkg::OP_WRCR))
      opc_next = sfd_pkg::ST_DIN;
    else
      opc_next = sfd_pkg::ST_DONE;
  endfunction

  logic [2:0]          cs_s;
  logic [2:0]          sck_s;
  sfd_pkg::sfd_lines_t dat_m;
  sfd_pkg::sfd_lines_t dat_s;
  sfd_pkg::sfd_state_t state_q;
  logic [7:0]          op_q;
  logic [31:0]         in_sr_q;
  logic [31:0]         addr_q;
  logic [5:0]          bit_cnt_q;
  logic [3:0]          dum_n_q;
  logic [1:0]          nb_q;
  logic                ok_q;
  logic [7:0]          osr_q;
  logic [7:0]          osr_d;
  logic [7:0]          byte_src;
  logic [2:0]          ocnt_q;
  logic [1:0]          idx_q;
  logic                first_q;
  logic [ARRAY_AW-1:0] rd_addr_q;
  logic [7:0]          off_q;
  logic                pend_q;
  logic [7:0]          rd_buf_q;
  logic [15:0]         cr_sh_q;
  logic                wel_q;
  logic                wide_q;
  logic [15:0]         cr_q;

  wire logic        cs_hi    = cs_s[1];
  wire logic        cs_rise  = cs_s[1] & ~cs_s[2];
  wire logic        sck_rise = sck_s[1] & ~sck_s[2];
  wire logic        sck_fall = ~sck_s[1] & sck_s[2];
  wire logic [2:0]  w        = lane_w(op_q);
  wire logic [31:0] sh       = shift_in(in_sr_q, dat_s, w);
  wire logic [31:0] sh_one   = shift_in(in_sr_q, dat_s, 3'h1);
  wire logic [5:0]  bc_next  = bit_cnt_q + {3'h0, w};
  wire logic [5:0]  abits    = ((op_q == sfd_pkg::OP_SSE) || !wide_q) ?
                               sfd_pkg::ADDR_BITS_3 : sfd_pkg::ADDR_BITS_4;
  wire logic        in_dout  = (state_q == sfd_pkg::ST_DOUT);
  wire logic        din_byte = (state_q == sfd_pkg::ST_DIN) && sck_rise &&
                               (bc_next == sfd_pkg::BYTE_BITS);
  wire logic        fetch    = in_dout && is_array_rd(op_q) &&
                               (first_q || (sck_fall && (ocnt_q == 3'h0)));
  wire logic        cmt      = cs_rise && ok_q;

  // pin synchronisers
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cs_s  <= 3'h7;
      sck_s <= 3'h0;
      dat_m <= '0;
      dat_s <= '0;
    end
    else
    begin
      cs_s  <= {cs_s[1:0], chip_select_low_in};
      sck_s <= {sck_s[1:0], serial_clock_in};
      dat_m <= serial_lines_in;
      dat_s <= dat_m;
    end
  end

  // command phase sequencer
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_q   <= sfd_pkg::ST_OPC;
      op_q      <= 8'h00;
      in_sr_q   <= 32'h0;
      addr_q    <= 32'h0;
      bit_cnt_q <= 6'h00;
      dum_n_q   <= 4'h0;
      nb_q      <= 2'h0;
      ok_q      <= 1'b0;
    end
    else if (cs_hi)
    begin
      state_q   <= sfd_pkg::ST_OPC;
      bit_cnt_q <= 6'h00;
      nb_q      <= 2'h0;
      ok_q      <= 1'b0;
    end
    else if (sck_rise)
    begin
      unique case (state_q)
        sfd_pkg::ST_OPC:
        begin
          in_sr_q   <= sh_one;
          bit_cnt_q <= bit_cnt_q + 6'h01;
          if (bit_cnt_q == sfd_pkg::OPC_LAST)
          begin
            op_q      <= sh_one[7:0];
            bit_cnt_q <= 6'h00;
            state_q   <= opc_next(sh_one[7:0], busy_in);
            ok_q      <= (opc_next(sh_one[7:0], busy_in) == sfd_pkg::ST_DONE);
            dum_n_q   <= dummy_for(sh_one[7:0], cr_q);
          end
        end
        sfd_pkg::ST_ADDR:
        begin
          in_sr_q   <= sh;
          bit_cnt_q <= bc_next;
          if (bc_next == abits)
          begin
            addr_q    <= (abits == sfd_pkg::ADDR_BITS_4) ? sh : {8'h00, sh[23:0]};
            bit_cnt_q <= 6'h00;
            if (is_page(op_q))
              state_q <= sfd_pkg::ST_DIN;
            else if (!is_array_rd(op_q))
            begin
              state_q <= sfd_pkg::ST_DONE;
              ok_q    <= 1'b1;
            end
            else if (dum_n_q == 4'h0)
              state_q <= sfd_pkg::ST_DOUT;
            else
              state_q <= sfd_pkg::ST_DUMMY;
          end
        end
        sfd_pkg::ST_DUMMY:
        begin
          bit_cnt_q <= bit_cnt_q + 6'h01;
          if ((bit_cnt_q + 6'h01) == {2'h0, dum_n_q})
            state_q <= sfd_pkg::ST_DOUT;
        end
        sfd_pkg::ST_DIN:
        begin
          in_sr_q   <= sh;
          bit_cnt_q <= din_byte ? 6'h00 : bc_next;
          ok_q      <= din_byte;
          if (din_byte && (nb_q != 2'h3))
            nb_q <= nb_q + 2'h1;
        end
        sfd_pkg::ST_DOUT:
          ok_q <= 1'b0;
        sfd_pkg::ST_DONE:
          ok_q <= 1'b0;
      endcase
    end
  end

  // next output byte source
  always_comb
  begin
    unique case (op_q)
      sfd_pkg::OP_RDSR:
        byte_src = {status_ext_in[7:2], wel_q, busy_in};
      sfd_pkg::OP_RDFS:
        byte_src = {~busy_in, flag_ext_in[6:1], wide_q};
      // register low then high, then zero
      sfd_pkg::OP_RDCR:
        byte_src = (idx_q == 2'h0) ? cr_q[7:0] : (idx_q == 2'h1) ? cr_q[15:8] : 8'h00;
      sfd_pkg::OP_RDID:
        byte_src = (idx_q == 2'h0) ? DEVICE_ID : 8'h00;
      default:
        byte_src = rd_buf_q;
    endcase
    osr_d = (ocnt_q == 3'h0) ? byte_src : (osr_q << w);
  end

  // output shifter, driven on falling edges
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      osr_q               <= 8'h00;
      ocnt_q              <= 3'h0;
      idx_q               <= 2'h0;
      first_q             <= 1'b1;
      serial_lines_out    <= '0;
      serial_lines_oe_out <= '0;
    end
    else
    begin
      first_q <= !in_dout;
      if (!in_dout)
      begin
        ocnt_q              <= 3'h0;
        idx_q               <= 2'h0;
        serial_lines_oe_out <= '0;
        serial_lines_out    <= '0;
      end
      else if (sck_fall)
      begin
        osr_q  <= osr_d;
        ocnt_q <= ocnt_q + w;
        if ((ocnt_q == 3'h0) && (idx_q != 2'h2))
          idx_q <= idx_q + 2'h1;
        case (w)
          3'h4:
          begin
            serial_lines_out    <= sfd_pkg::sfd_lines_t'(osr_d[7:4]);
            serial_lines_oe_out <= sfd_pkg::sfd_lines_t'(4'hF);
          end
          3'h2:
          begin
            serial_lines_out    <= sfd_pkg::sfd_lines_t'({2'h0, osr_d[7:6]});
            serial_lines_oe_out <= sfd_pkg::sfd_lines_t'(4'h3);
          end
          default:
          begin
            serial_lines_out    <= sfd_pkg::sfd_lines_t'({2'h0, osr_d[7], 1'b0});
            serial_lines_oe_out <= sfd_pkg::sfd_lines_t'(4'h2);
          end
        endcase
      end
    end
  end

  // memory array port
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      array_rd_out    <= 1'b0;
      array_wr_out    <= 1'b0;
      array_addr_out  <= 32'h0;
      array_wdata_out <= 8'h00;
      rd_addr_q       <= '0;
      off_q           <= 8'h00;
      pend_q          <= 1'b0;
      rd_buf_q        <= 8'h00;
    end
    else
    begin
      array_rd_out <= fetch;
      array_wr_out <= din_byte && is_page(op_q);
      pend_q       <= array_rd_out;
      if (pend_q)
        rd_buf_q <= array_rdata_in;
      // advance and wrap at top of array
      if (fetch && first_q)
      begin
        array_addr_out <= 32'(addr_q[ARRAY_AW-1:0]);
        rd_addr_q      <= addr_q[ARRAY_AW-1:0] + 1'b1;
      end
      else if (fetch)
      begin
        array_addr_out <= 32'(rd_addr_q);
        rd_addr_q      <= rd_addr_q + 1'b1;
      end
      // byte count within page, zero outside data phase
      if (state_q != sfd_pkg::ST_DIN)
        off_q <= 8'h00;
      if (din_byte)
      begin
        array_wdata_out <= sh[7:0];
        off_q           <= off_q + 8'h01;
        if (is_page(op_q))
          array_addr_out <= {addr_q[31:8], addr_q[7:0] + off_q};
      end
      if (cmt && is_prog(op_q))
        array_addr_out <= addr_q;
    end
  end

  // write enable latch, addressing mode, configuration register
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wel_q        <= 1'b0;
      wide_q       <= ~CR_INIT[sfd_pkg::CR_ADDR];
      cr_q         <= CR_INIT;
      cr_sh_q      <= 16'h0;
      op_start_out <= 1'b0;
      op_code_out  <= 8'h00;
    end
    else
    begin
      if (din_byte && (op_q == sfd_pkg::OP_WRCR) && (nb_q == 2'h0))
        cr_sh_q[7:0] <= sh[7:0];
      if (din_byte && (op_q == sfd_pkg::OP_WRCR) && (nb_q == 2'h1))
        cr_sh_q[15:8] <= sh[7:0];
      // launch only when enabled and idle
      op_start_out <= cmt && wel_q && !busy_in && is_prog(op_q);
      if (cmt && wel_q && !busy_in && is_prog(op_q))
        op_code_out <= op_q;
      if (op_done_in)
        wel_q <= 1'b0;
      if (cmt && wel_q && (op_q == sfd_pkg::OP_WRCR) && (nb_q == sfd_pkg::CR_BYTES))
      begin
        cr_q  <= cr_sh_q;
        wel_q <= 1'b0;
      end
      if (cmt && wel_q && (op_q == sfd_pkg::OP_WIDE_IN))
        wide_q <= 1'b1;
      if (cmt && wel_q && (op_q == sfd_pkg::OP_WIDE_OUT))
        wide_q <= 1'b0;
      if (cmt && (op_q == sfd_pkg::OP_WRDI))
        wel_q <= 1'b0;
      if (cmt && (op_q == sfd_pkg::OP_WREN))
        wel_q <= 1'b1;
    end
  end

  // status outputs
  assign write_enable_out = wel_q;
  assign wide_address_out = wide_q;
  assign config_out       = cr_q;

endmodule

// ==== bench/sfd_cmd_decoder_chk.sv ====
`timescale 1ns/1ns
// pin-level watcher for the decoder
module sfd_cmd_decoder_chk
#(
  parameter int unsigned ARRAY_AW = 24
)
(
  // clock and reset
  input wire logic                ref_clk_in,
  input wire logic                arst_n_in,
  // link and engine pins
  input wire logic                chip_select_low_in,
  input wire logic                serial_clock_in,
  input wire sfd_pkg::sfd_lines_t serial_lines_out,
  input wire sfd_pkg::sfd_lines_t serial_lines_oe_out,
  input wire logic                array_rd_out,
  input wire logic                op_start_out,
  input wire logic                busy_in,
  input wire logic                op_done_in,
  input wire logic                write_enable_out,
  input wire logic                wide_address_out,
  input wire logic [15:0]         config_out
);
  default clocking dck @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  AST_OE_IDLE: assert property (chip_select_low_in [*5] |-> serial_lines_oe_out == 4'h0)
    else $error("lines driven outside frame");
  AST_OUT_ON_FALL: assert property ($changed(serial_lines_out) &&
    $past(serial_lines_oe_out) != 4'h0 && serial_lines_oe_out != 4'h0
    |-> !$past(serial_clock_in) && !$past(serial_clock_in, 2))
    else $error("data changed off falling edge");
  AST_RD_SPACING: assert property (array_rd_out |=> !array_rd_out [*2])
    else $error("fetches too close");
  AST_RD_STREAM: assert property (array_rd_out ##1 !array_rd_out [*2] ##1 array_rd_out
    |=> !array_rd_out [*8])
    else $error("stream fetches too close");
  AST_NO_READ_BUSY: assert property (busy_in [*8] |-> !array_rd_out)
    else $error("fetch during busy cycle");
  AST_WEL_SET: assert property ($rose(write_enable_out)
    |-> chip_select_low_in && $past(chip_select_low_in, 2))
    else $error("latch set inside frame");
  AST_WEL_DONE: assert property (chip_select_low_in [*5] ##0 op_done_in
    |=> !write_enable_out)
    else $error("latch kept after completion");
  AST_START_WEL: assert property (op_start_out
    |-> write_enable_out && chip_select_low_in ##1 !op_start_out)
    else $error("start without latch");
  AST_WIDE_WEL: assert property ($changed(wide_address_out) |-> write_enable_out)
    else $error("width changed without latch");
  AST_CFG_WEL: assert property ($changed(config_out)
    |-> $past(write_enable_out) && !write_enable_out)
    else $error("config changed without latch");
endmodule

bind sfd_cmd_decoder sfd_cmd_decoder_chk #(.ARRAY_AW(ARRAY_AW)) i_chk
(
  .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .chip_select_low_in(chip_select_low_in),
  .serial_clock_in(serial_clock_in), .serial_lines_out(serial_lines_out),
  .serial_lines_oe_out(serial_lines_oe_out), .array_rd_out(array_rd_out),
  .op_start_out(op_start_out), .busy_in(busy_in), .op_done_in(op_done_in),
  .write_enable_out(write_enable_out), .wide_address_out(wide_address_out),
  .config_out(config_out)
);

// ==== bench/sfd_host_model.sv ====
`timescale 1ns/1ns
// host end of the link; frames are built by task calls
module sfd_host_model
(
  // timing reference
  input  wire logic       ref_clk_in,
  // link pins
  output      logic       cs_n_out,
  output      logic       sck_out,
  output      logic [3:0] lines_out,
  output      logic [3:0] lines_oe_out,
  input  wire logic [3:0] lines_in
);
  // idle: deselected, clock still, lines released
  initial
  begin
    cs_n_out     = 1'b1;
    sck_out      = 1'b0;
    lines_out    = 4'h0;
    lines_oe_out = 4'h0;
  end

  // select, offset from system clock
  task automatic open_frame();
    @(posedge ref_clk_in);
    #3 cs_n_out = 1'b0;
    #40;
  endtask

  task automatic close_frame();
    #40 cs_n_out = 1'b1;
    lines_oe_out = 4'h0;
    #200;
  endtask

  task automatic xfer(input logic [7:0] wb, input int w, input bit drv,
                      output logic [7:0] rb);
    rb = 8'h00;
    for (int k = 0; k < 8 / w; k++)
    begin
      sck_out      = 1'b0;
      lines_oe_out = drv ? 4'((1 << w) - 1) : 4'h0;
      lines_out    = 4'(wb[7:4] >> (4 - w));
      wb           = wb << w;
      #78;
      rb = (rb << w) | ((w == 1) ? {7'h0, lines_in[1]} : {4'h0, lines_in & 4'((1 << w) - 1)});
      #2 sck_out = 1'b1;
      #80;
    end
    sck_out = 1'b0;
  endtask

  // clocks with lines released
  task automatic dummies(input int n);
    lines_oe_out = 4'h0;
    repeat (n)
    begin
      #80 sck_out = 1'b1;
      #80 sck_out = 1'b0;
    end
  endtask
endmodule

// ==== bench/sfd_cmd_decoder_tb.sv ====
`timescale 1ns/1ns
// drives the decoder through the host model
module sfd_cmd_decoder_tb;
  localparam logic [7:0] ID_VAL = 8'h3C;  // arbitrary value
  localparam logic [7:0] ST_EXT = 8'hA8;
  localparam logic [7:0] FL_EXT = 8'h5A;
  logic                ref_clk, arst_n, busy, op_done, flip, cs_n, sck;
  logic                rd, wr, start, wel, wide;
  logic [3:0]          h_val, h_oe, wire_lv;
  sfd_pkg::sfd_lines_t l_out, l_oe;
  logic [31:0]         addr;
  logic [7:0]          wdata, rdata, opc, rb;
  logic [15:0]         cfg;
  logic [15:0]         wr_q[$];
  logic [7:0]          start_q[$];
  int                  fails, compares;
  logic [7:0]          pgm_op[7], fr_op[3];
  int                  pgm_w[7], pgm_n[7], fr_w[3];

  sfd_cmd_decoder #(.DEVICE_ID(ID_VAL)) i_dut
  (
    .ref_clk_in(ref_clk), .arst_n_in(arst_n), .chip_select_low_in(cs_n),
    .serial_clock_in(sck), .serial_lines_in(sfd_pkg::sfd_lines_t'(wire_lv)),
    .serial_lines_out(l_out), .serial_lines_oe_out(l_oe), .array_rd_out(rd),
    .array_wr_out(wr), .array_addr_out(addr), .array_wdata_out(wdata),
    .array_rdata_in(rdata), .op_start_out(start), .op_code_out(opc), .busy_in(busy),
    .op_done_in(op_done), .status_ext_in(ST_EXT), .flag_ext_in(FL_EXT),
    .write_enable_out(wel), .wide_address_out(wide), .config_out(cfg)
  );
  sfd_host_model i_host
  (
    .ref_clk_in(ref_clk), .cs_n_out(cs_n), .sck_out(sck), .lines_out(h_val),
    .lines_oe_out(h_oe), .lines_in(wire_lv)
  );

  // wire level: device, else host, else a changing pattern
  assign wire_lv = (4'(l_oe) & 4'(l_out)) | (~4'(l_oe) & h_oe & h_val)
                 | (~4'(l_oe) & ~h_oe & {4{flip}});

  // clock
  always #10 ref_clk = ~ref_clk;

  // array and engine stand-in, data one cycle after strobe
  always @(posedge ref_clk)
  begin
    flip <= ~flip;
    if (rd) rdata <= addr[7:0] ^ 8'hA5;
    if (wr) wr_q.push_back({addr[7:0], wdata});
    if (start) start_q.push_back(opc);
  end

  // compare a byte
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  // compare a level or count
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  // link helpers
  task automatic send(input logic [7:0] b, input int w);
    i_host.xfer(b, w, 1'b1, rb);
  endtask
  task automatic get(input int w, input logic [7:0] exp);
    i_host.xfer(8'h00, w, 1'b0, rb);
    chk_byte(rb, exp);
  endtask
  task automatic send_addr(input logic [31:0] a, input int w, input int n);
    for (int i = n - 1; i >= 0; i--) send(a[8 * i +: 8], w);
  endtask
  task automatic op1(input logic [7:0] op);
    i_host.open_frame();
    send(op, 1);
    i_host.close_frame();
  endtask

  // self-timed cycle finishes
  task automatic pulse_done();
    @(posedge ref_clk) #3 op_done = 1'b1;
    @(posedge ref_clk) #3 op_done = 1'b0;
    @(posedge ref_clk);
  endtask

  // three fast read kinds, two bytes each
  task automatic fast_reads(input int d8, input int d10);
    for (int i = 0; i < 3; i++)
    begin
      i_host.open_frame();
      send(fr_op[i], 1);
      send_addr(32'h100 + 16 * i, fr_w[i], 3);
      i_host.dummies((i == 2) ? d10 : d8);
      get(fr_w[i], 8'(16 * i) ^ 8'hA5);
      get(fr_w[i], 8'(16 * i + 1) ^ 8'hA5);
      i_host.close_frame();
    end
  endtask

  // verdict
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #1000000;
    fails++;
    close_out();
  end

  // main sequence
  initial
  begin
    ref_clk = 1'b0;
    arst_n  = 1'b0;
    busy    = 1'b0;
    op_done = 1'b0;
    flip    = 1'b0;
    rdata   = 8'h00;
    fails    = 0;
    compares = 0;
    pgm_op = '{sfd_pkg::OP_PP, sfd_pkg::OP_DPP, sfd_pkg::OP_QPP, sfd_pkg::OP_QPP2,
               sfd_pkg::OP_SE, sfd_pkg::OP_SSE, sfd_pkg::OP_BE};
    pgm_w  = '{1, 2, 4, 4, 1, 1, 1};
    pgm_n  = '{258, 1, 1, 1, 0, 0, 0};
    fr_op  = '{sfd_pkg::OP_FRD, sfd_pkg::OP_DRD, sfd_pkg::OP_QRD};
    fr_w   = '{1, 2, 4};
    repeat (2) @(posedge ref_clk);
    #3 arst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    chk_val(cfg, 16'hFFFF);
    chk_val(wide, 0);
    chk_val(wel, 0);
    op1(sfd_pkg::OP_WREN);
    chk_val(wel, 1);
    i_host.open_frame();
    send(sfd_pkg::OP_RDSR, 1);
    repeat (2) get(1, {ST_EXT[7:2], 2'b10});
    i_host.close_frame();
    op1(sfd_pkg::OP_WRDI);
    chk_val(wel, 0);
    i_host.open_frame();
    send(sfd_pkg::OP_RDFS, 1);
    repeat (2) get(1, {1'b1, FL_EXT[6:1], 1'b0});
    i_host.close_frame();
    i_host.open_frame();
    send(sfd_pkg::OP_RDCR, 1);
    repeat (2) get(1, 8'hFF);
    i_host.close_frame();
    i_host.open_frame();
    send(sfd_pkg::OP_RDID, 1);
    i_host.dummies(2);
    get(1, ID_VAL);
    i_host.close_frame();
    i_host.open_frame();
    send(sfd_pkg::OP_READ, 1);
    send_addr(32'hFFFFFE, 1, 3);
    for (int i = 0; i < 3; i++) get(1, 8'(8'hFE + i) ^ 8'hA5);
    i_host.close_frame();
    fast_reads(8, 10);
    op1(sfd_pkg::OP_WREN);
    i_host.open_frame();
    send(sfd_pkg::OP_WRCR, 1);
    send(8'hFF, 1);
    send(8'h3F, 1);
    i_host.close_frame();
    chk_val(cfg, 16'h3FFF);
    fast_reads(3, 3);
    op1(sfd_pkg::OP_WIDE_IN);
    chk_val(wide, 0);
    op1(sfd_pkg::OP_WREN);
    op1(sfd_pkg::OP_WIDE_IN);
    chk_val(wide, 1);
    i_host.open_frame();
    send(sfd_pkg::OP_READ, 1);
    send_addr(32'h10, 1, 4);
    get(1, 8'h10 ^ 8'hA5);
    i_host.close_frame();
    op1(sfd_pkg::OP_WIDE_OUT);
    chk_val(wide, 0);
    op1(sfd_pkg::OP_WRDI);
    for (int i = 0; i < 7; i++)
    begin
      op1(sfd_pkg::OP_WREN);
      i_host.open_frame();
      send(pgm_op[i], 1);
      if (pgm_op[i] != sfd_pkg::OP_BE) send_addr(32'h200, pgm_w[i], 3);
      for (int n = 0; n < pgm_n[i]; n++) send(8'(n) ^ 8'h3C, pgm_w[i]);
      i_host.close_frame();
      chk_byte(start_q.pop_front(), pgm_op[i]);
      pulse_done();
      chk_val(wel, 0);
    end
    chk_val(wr_q.size(), 261);
    chk_val(wr_q[257], 16'h013D);
    @(posedge ref_clk) #3 busy = 1'b1;
    i_host.open_frame();
    send(sfd_pkg::OP_RDSR, 1);
    get(1, {ST_EXT[7:2], 2'b01});
    i_host.close_frame();
    i_host.open_frame();
    send(sfd_pkg::OP_READ, 1);
    send_addr(32'h10, 1, 3);
    i_host.xfer(8'h00, 1, 1'b0, rb);
    chk_val(l_oe, 0);
    i_host.close_frame();
    @(posedge ref_clk) #3 busy = 1'b0;
    close_out();
  end
endmodule
